/* File: asi_alert_status.sv */
// Status, event latch, alert mask and bus slave of the converter host port.
// Notes on behaviour
// - Status bit 7 shows output power good.
// - Status bit 6 shows thermal shutdown state.
// - Status bit 5 shows thermal warning state.
// - Status bit 4: zero voltage, one current mode.
// - Status bits are live, never latched.
// - Events stick; writing 0xee clears them all.
// - Event 7 on thermal shutdown entry, masked by bit 4.
// - Event 6 on warning entry, above 120 C.
// - Event 5 on entering current limiting.
// - Event 4 on leaving limit, not hiccup.
// - Event 3 on output undervoltage.
// - Event 2 on thermal shutdown exit.
// - Event 1 when warning ends below 100 C.
// - Event 0 on power good rising.
// - Mask bit 4 gates shutdown events off alert.
// - Mask bit 3 gates warning events off alert.
// - Mask bit 2 gates both current limit events.
// - Mask bit 1 gates undervoltage events off alert.
// - Mask bit 0 gates power good events.
module asi_alert_status
    import asi_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire asi_cond_t cond,
    input  wire logic      scl_i,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe_n,
    output logic           alert_n
);

    logic           rst_meta;
    logic           rst_n;
    asi_cond_t      cond_q;
    asi_cond_t      cond_p;
    logic [MASK_W-1:0] mask;
    logic [7:0]     events;
    logic           scl_q;
    logic           sda_q;
    logic           scl_p;
    logic           sda_p;
    asi_bus_state_t state;
    asi_bus_state_t next_state;
    logic [2:0]     bits;
    logic [2:0]     next_bits;
    logic [7:0]     shreg;
    logic [7:0]     next_shreg;
    logic [7:0]     tx;
    logic [7:0]     next_tx;
    logic [7:0]     ptr;
    logic [7:0]     next_ptr;
    logic           rw;
    logic           next_rw;
    logic           drive;
    logic           next_drive;
    logic           full;
    logic           next_full;
    logic           mack;
    logic           next_mack;
    asi_wr_t        wr;

    wire logic       scl_rise;
    wire logic       scl_fall;
    wire logic       start_det;
    wire logic       stop_det;
    wire logic       mask_wr;
    wire logic       evt_clear;
    wire logic       cl_now;
    wire logic       cl_prev;
    wire logic [7:0] status_byte;
    wire logic [7:0] rd_data;
    wire logic [7:0] trig;
    wire logic [7:0] gate;

    // Reset is released through two flops so every flop leaves it together.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Conditions are sampled, then kept one more cycle for edge detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_q <= '0;
            cond_p <= '0;
        end else begin
            cond_q <= cond;
            cond_p <= cond_q;
        end
    end

    // Live status follows the sampled conditions with no latching.
    assign status_byte[ST_POWER_GOOD] = cond_q.power_good;
    assign status_byte[ST_TSD]  = cond_q.thermal_shutdown;
    assign status_byte[ST_WARN] = cond_q.thermal_warning_state;
    assign status_byte[ST_REG_MODE] = cond_q.regulation_mode_flag;
    assign status_byte[3:0] = 4'h0;

    // Event triggers are edges of the sampled conditions.
    assign cl_now  = cond_q.regulation_mode_flag | cond_q.over_current;
    assign cl_prev = cond_p.regulation_mode_flag | cond_p.over_current;
    assign trig[EV_TSD_ENTRY] = cond_q.thermal_shutdown
                              & ~cond_p.thermal_shutdown;
    assign trig[EV_WARN_ENTRY] = cond_q.thermal_warning_state
                               & ~cond_p.thermal_warning_state;
    assign trig[EV_CL_ENTRY] = cl_now & ~cl_prev;
    // A restart out of hiccup is not a recovery from limiting.
    assign trig[EV_CL_EXIT] = ~cond_q.regulation_mode_flag
                            & cond_p.regulation_mode_flag
                            & ~cond_q.hiccup_recovery;
    assign trig[EV_UV] = cond_q.undervoltage & ~cond_p.undervoltage;
    assign trig[EV_TSD_EXIT] = ~cond_q.thermal_shutdown
                             & cond_p.thermal_shutdown;
    assign trig[EV_WARN_EXIT] = ~cond_q.thermal_warning_state
                              & cond_p.thermal_warning_state;
    assign trig[EV_PG_RISE] = cond_q.power_good
                            & ~cond_p.power_good;

    // Only the exact clear code clears; other event writes are ignored.
    assign evt_clear = wr.en && (wr.addr == OFF_EVENTS)
                    && (wr.data == EVT_CLEAR_CODE);
    assign mask_wr = wr.en && (wr.addr == OFF_MASK);

    asi_event_latch u_latch (
        .clk       (clk),
        .rst_n     (rst_n),
        .set_pulse (trig),
        .clear     (evt_clear),
        .latched   (events)
    );

    // Mask bits reach only the alert path, never the event bits.
    assign gate[EV_TSD_ENTRY]  = mask[MK_TSD];
    assign gate[EV_TSD_EXIT]   = mask[MK_TSD];
    assign gate[EV_WARN_ENTRY] = mask[MK_WARN];
    assign gate[EV_WARN_EXIT]  = mask[MK_WARN];
    assign gate[EV_CL_ENTRY]   = mask[MK_CL];
    assign gate[EV_CL_EXIT]    = mask[MK_CL];
    assign gate[EV_UV]         = mask[MK_UV];
    assign gate[EV_PG_RISE]    = mask[MK_PG];

    // Mask register; reserved upper bits are dropped on write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= MASK_RESET;
        end else if (mask_wr) begin
            mask <= wr.data[MASK_W-1:0];
        end
    end

    // Alert pin is active low and released once no unmasked event remains.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= ~|(events & ~gate);
        end
    end

    // Read data for the byte addressed by the pointer; unmapped reads zero.
    assign rd_data = (ptr == OFF_STATUS) ? status_byte :
                     (ptr == OFF_EVENTS) ? events :
                     (ptr == OFF_MASK)   ? {3'h0, mask} : 8'h00;

    // Bus lines are sampled once; the previous sample gives the edges.
    assign scl_rise  = scl_q & ~scl_p;
    assign scl_fall  = ~scl_q & scl_p;
    assign start_det = scl_q & scl_p & sda_p & ~sda_q;
    assign stop_det  = scl_q & scl_p & ~sda_p & sda_q;

    // Byte engine: address, pointer, then write bytes or read bytes.
    // The slave only changes the data line after a clock fall, so its own
    // drive can never look like a start or stop to the detectors.
    always_comb begin
        next_state = state;
        next_bits  = bits;
        next_shreg = shreg;
        next_tx    = tx;
        next_ptr   = ptr;
        next_rw    = rw;
        next_drive = drive;
        next_full  = full;
        next_mack  = mack;
        wr         = '0;
        if (start_det) begin
            next_state = S_ADDR;
            next_bits  = 3'd0;
            next_full  = 1'b0;
            next_drive = 1'b0;
        end else if (stop_det) begin
            next_state = S_IDLE;
            next_drive = 1'b0;
        end else begin
            case (state)
                S_ADDR, S_PTR, S_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_q};
                        next_bits  = bits + 3'd1;
                        next_full  = (bits == 3'd7);
                    end else if (scl_fall && full) begin
                        next_full  = 1'b0;
                        next_drive = 1'b1;
                        if (state == S_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR_DEF) begin
                                next_rw    = shreg[0];
                                next_state = S_ADDR_ACK;
                            end else begin
                                next_drive = 1'b0;
                                next_state = S_IDLE;
                            end
                        end else if (state == S_PTR) begin
                            next_ptr   = shreg;
                            next_state = S_PTR_ACK;
                        end else begin
                            wr.en      = 1'b1;
                            wr.addr    = ptr;
                            wr.data    = shreg;
                            next_ptr   = ptr + 8'h01;
                            next_state = S_WDATA_ACK;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bits = 3'd0;
                        if (rw) begin
                            next_tx    = rd_data;
                            next_ptr   = ptr + 8'h01;
                            next_drive = ~rd_data[7];
                            next_state = S_RDATA;
                        end else begin
                            next_drive = 1'b0;
                            next_state = S_PTR;
                        end
                    end
                end
                S_PTR_ACK, S_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_drive = 1'b0;
                        next_bits  = 3'd0;
                        next_state = S_WDATA;
                    end
                end
                S_RDATA: begin
                    if (scl_fall) begin
                        if (bits == 3'd7) begin
                            next_drive = 1'b0;
                            next_state = S_RDATA_ACK;
                        end else begin
                            next_tx    = {tx[6:0], 1'b0};
                            next_drive = ~tx[6];
                        end
                        next_bits = bits + 3'd1;
                    end
                end
                S_RDATA_ACK: begin
                    if (scl_rise) begin
                        next_mack = ~sda_q;
                    end else if (scl_fall) begin
                        if (mack) begin
                            next_tx    = rd_data;
                            next_ptr   = ptr + 8'h01;
                            next_drive = ~rd_data[7];
                            next_state = S_RDATA;
                        end else begin
                            next_state = S_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    // Bus pin samples.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    // Byte engine state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            bits  <= 3'd0;
            shreg <= 8'h00;
            tx    <= 8'h00;
            ptr   <= 8'h00;
            rw    <= 1'b0;
            drive <= 1'b0;
            full  <= 1'b0;
            mack  <= 1'b0;
        end else begin
            state <= next_state;
            bits  <= next_bits;
            shreg <= next_shreg;
            tx    <= next_tx;
            ptr   <= next_ptr;
            rw    <= next_rw;
            drive <= next_drive;
            full  <= next_full;
            mack  <= next_mack;
        end
    end

    // Open-drain data line: the enable is low only while pulling low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_o    <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_o    <= 1'b0;
            sda_oe_n <= ~next_drive;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pg_live: assert property (
        (ptr == OFF_STATUS) |-> rd_data[ST_POWER_GOOD]
                                == $past(cond.power_good))
        else $error("Power good status does not follow the input.");
    a_tsd_live: assert property (
        (ptr == OFF_STATUS) |-> rd_data[ST_TSD]
                                == $past(cond.thermal_shutdown))
        else $error("Shutdown status does not follow the input.");
    a_warn_live: assert property (
        (ptr == OFF_STATUS) |-> rd_data[ST_WARN]
                                == $past(cond.thermal_warning_state))
        else $error("Warning status does not follow the input.");
    a_mode_live: assert property (
        (ptr == OFF_STATUS) |-> rd_data[ST_REG_MODE]
                                == $past(cond.regulation_mode_flag))
        else $error("Regulation mode status is wrong.");
    a_status_unlatched: assert property (
        $fell(cond.power_good) |=> !status_byte[ST_POWER_GOOD])
        else $error("Status bit stayed set after its condition ended.");
    a_clear_code: assert property (
        (evt_clear && trig == 8'h00) |=> (events == 8'h00) ##1 alert_n)
        else $error("Clear code did not clear events and alert.");
    a_tsd_entry: assert property (
        $rose(cond_q.thermal_shutdown) |=> events[EV_TSD_ENTRY])
        else $error("Shutdown entry event missing.");
    a_warn_entry: assert property (
        $rose(cond_q.thermal_warning_state) |=> events[EV_WARN_ENTRY])
        else $error("Warning entry event missing.");
    a_cl_entry: assert property (
        $rose(cl_now) |=> events[EV_CL_ENTRY])
        else $error("Current limit entry event missing.");
    a_cl_exit: assert property (
        ($fell(cond_q.regulation_mode_flag) && !cond_q.hiccup_recovery)
        |=> events[EV_CL_EXIT])
        else $error("Current limit exit event missing.");
    a_uv_event: assert property (
        $rose(cond_q.undervoltage) |=> events[EV_UV])
        else $error("Undervoltage event missing.");
    a_tsd_exit: assert property (
        $fell(cond_q.thermal_shutdown) |=> events[EV_TSD_EXIT])
        else $error("Shutdown exit event missing.");
    a_warn_exit: assert property (
        $fell(cond_q.thermal_warning_state) |=> events[EV_WARN_EXIT])
        else $error("Warning exit event missing.");
    a_pg_rise: assert property (
        $rose(cond_q.power_good) |=> events[EV_PG_RISE])
        else $error("Power good rising event missing.");
    a_tsd_gated: assert property (
        (mask[MK_TSD] && events == (8'h01 << EV_TSD_EXIT)) |=> alert_n)
        else $error("Masked shutdown event reached the alert pin.");
    a_warn_gated: assert property (
        (mask[MK_WARN] && events == (8'h01 << EV_WARN_EXIT)) |=> alert_n)
        else $error("Masked warning event reached the alert pin.");
    a_cl_gated: assert property (
        (mask[MK_CL] && events == (8'h01 << EV_CL_EXIT)) |=> alert_n)
        else $error("Masked current limit event reached the alert pin.");
    a_uv_gated: assert property (
        (mask[MK_UV] && events == (8'h01 << EV_UV)) |=> alert_n)
        else $error("Masked undervoltage event reached the alert pin.");
    a_pg_shown: assert property (
        (!mask[MK_PG] && events[EV_PG_RISE]) |=> !alert_n)
        else $error("Unmasked power good event missed the alert pin.");
    a_alert_follows: assert property (
        (|(events & ~gate)) [*2] |=> !alert_n)
        else $error("Alert not asserted for a pending unmasked event.");

    c_clear: cover property (evt_clear ##1 alert_n);
    c_alert: cover property ($fell(alert_n));
    c_read_burst: cover property (state == S_RDATA_ACK && scl_fall && mack);
    c_mask_write: cover property (mask_wr && wr.data[MK_TSD]);

endmodule

/* File: asi_pkg.sv */
// Constants, field positions and carrier types of the alert and status block.
package asi_pkg;

    // Register offsets, reached through the pointer byte of a bus write.
    localparam logic [7:0] OFF_STATUS     = 8'h00;
    localparam logic [7:0] OFF_EVENTS     = 8'h01;
    localparam logic [7:0] OFF_MASK       = 8'h02;

    // Writing this code to the event register clears every latched bit.
    localparam logic [7:0] EVT_CLEAR_CODE = 8'hee;

    // Default bus address of the device; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR_DEF   = 7'h2a;

    // Live status bit positions.
    localparam int ST_POWER_GOOD = 7;
    localparam int ST_TSD        = 6;
    localparam int ST_WARN       = 5;
    localparam int ST_REG_MODE   = 4;

    // Latched event bit positions.
    localparam int EV_TSD_ENTRY  = 7;
    localparam int EV_WARN_ENTRY = 6;
    localparam int EV_CL_ENTRY   = 5;
    localparam int EV_CL_EXIT    = 4;
    localparam int EV_UV         = 3;
    localparam int EV_TSD_EXIT   = 2;
    localparam int EV_WARN_EXIT  = 1;
    localparam int EV_PG_RISE    = 0;

    // Alert mask bit positions, width and reset value.
    localparam int MK_TSD  = 4;
    localparam int MK_WARN = 3;
    localparam int MK_CL   = 2;
    localparam int MK_UV   = 1;
    localparam int MK_PG   = 0;
    localparam int MASK_W  = 5;
    localparam logic [MASK_W-1:0] MASK_RESET = 5'h00;

    // Live converter conditions sampled by the block.
    typedef struct packed {
        logic power_good;
        logic thermal_shutdown;
        logic thermal_warning_state;
        logic regulation_mode_flag;
        logic over_current;
        logic undervoltage;
        logic hiccup_recovery;
    } asi_cond_t;

    // One register write decoded from the bus.
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } asi_wr_t;

    typedef enum {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
    } asi_bus_state_t;

endpackage

/* File: asi_event_latch.sv */
// Sticky event bits with a common clear; a new event beats the clear.
module asi_event_latch
    import asi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] set_pulse,
    input  wire logic       clear,
    output logic      [7:0] latched
);

    // Each bit holds until the clear code arrives; set wins the tie.
    for (genvar i = 0; i < 8; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                latched[i] <= 1'b0;
            end else if (set_pulse[i]) begin
                latched[i] <= 1'b1;
            end else if (clear) begin
                latched[i] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_set_beats_clear: assert property (
        (clear && set_pulse != 8'h00) |=> ((latched & $past(set_pulse))
                                           == $past(set_pulse)))
        else $error("An event was lost to a clear in the same cycle.");

    a_bits_stay_set: assert property (
        !clear |=> ((latched & $past(latched)) == $past(latched)))
        else $error("A latched event dropped without a clear.");

    a_clear_empties: assert property (
        (clear && set_pulse == 8'h00) |=> (latched == 8'h00))
        else $error("Clear left latched events set.");

endmodule

/* File: asi_host_model.sv */
// Bus host model: bit-level master tasks and register access.
module asi_host_model
    import asi_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both lines idle high, as the pull-ups leave them.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Eight edges a phase keep the bus clock low well past five cycles.
    task automatic tick();
        repeat (8) @(posedge clk);
    endtask

    // Data moves one edge after the clock falls, so no false start is seen.
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk);
        sda_drv <= b;
        tick();
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        r = sda;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask

    // Byte out msb first, then the ninth bit; returns what the wire showed.
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, ack);
    endtask

    // Start also serves as repeated start from a low bus clock.
    task automatic start();
        @(posedge clk);
        sda_drv <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_drv <= 1'b0;
        tick();
        scl <= 1'b0;
    endtask

    task automatic stop();
        @(posedge clk);
        sda_drv <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_drv <= 1'b1;
        tick();
    endtask

    // Register write; nak is high if any byte went unanswered.
    task automatic wr(input logic [6:0] dev, input logic [7:0] p,
                      input logic [7:0] v, output logic nak);
        logic [7:0] q;
        logic [2:0] n;
        start();
        xfer({dev, 1'b0}, 1'b1, q, n[0]);
        xfer(p, 1'b1, q, n[1]);
        xfer(v, 1'b1, q, n[2]);
        stop();
        nak = |n;
    endtask

    // Pointer write, repeated start, one byte read and closed by a NACK.
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic [7:0] q;
        logic       n;
        start();
        xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, q, n);
        xfer(p, 1'b1, q, n);
        start();
        xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, q, n);
        xfer(8'hff, 1'b1, v, n);
        stop();
    endtask

    // Two-byte read: ACK after the first byte, NACK after the second.
    task automatic rd2(input logic [7:0] p, output logic [7:0] v0,
                       output logic [7:0] v1);
        logic [7:0] q;
        logic       n;
        start();
        xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, q, n);
        xfer(p, 1'b1, q, n);
        start();
        xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, q, n);
        xfer(8'hff, 1'b0, v0, n);
        xfer(8'hff, 1'b1, v1, n);
        stop();
    endtask
endmodule

/* File: asi_alert_status_tb.sv */
// Self-checking bench of the alert and status block.
module asi_alert_status_tb
    import asi_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    asi_cond_t  cond = '0;
    logic       scl, sda_drv, sda_o, sda_oe_n, alert_n, r;
    logic [7:0] v, e;
    int         bad_count = 0;
    int         n_tests = 0;
    // Open drain wire: the device can only pull low.
    wire logic  sda = sda_drv & (sda_oe_n | sda_o);

    // Pre and post conditions that raise event 7 down to 0, then a hiccup.
    localparam logic [6:0] PRE [9] = '{7'h00, 7'h00, 7'h00, 7'h08, 7'h00,
                                       7'h20, 7'h10, 7'h00, 7'h09};
    localparam logic [6:0] POST [9] = '{7'h20, 7'h10, 7'h04, 7'h00, 7'h02,
                                        7'h00, 7'h00, 7'h40, 7'h01};

    always #25 clk = ~clk;

    asi_alert_status dut (.clk(clk), .resetn(resetn), .cond(cond),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .alert_n(alert_n));
    asi_host_model host (.clk(clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait for the alert level; running out ends the run.
    task automatic alert_is(logic x);
        for (int i = 0; i < 12 && alert_n !== x; i++)
            @(negedge clk);
        check("alert", {7'h0, alert_n}, {7'h0, x});
        if (alert_n !== x)
            conclude();
    endtask

    // Mask bit that gates a given event bit.
    function automatic int gate_of(int ev);
        case (ev)
            7, 2: return MK_TSD;
            6, 1: return MK_WARN;
            5, 4: return MK_CL;
            3: return MK_UV;
            default: return MK_PG;
        endcase
    endfunction

    function automatic logic [7:0] stat_of(asi_cond_t c);
        return {c.power_good, c.thermal_shutdown, c.thermal_warning_state,
                c.regulation_mode_flag, 4'h0};
    endfunction

    initial begin
        void'($urandom(26));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        alert_is(1'b1);
        host.rd(OFF_MASK, v);
        check("mask reset", v, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            cond <= asi_cond_t'(7'($urandom));
            repeat (4) @(posedge clk);
            host.rd(OFF_STATUS, v);
            check("status", v, stat_of(cond));
        end
        $display("test status done");
        // Each row: settle, clear, trigger, then gate and release the alert.
        for (int i = 0; i < 9; i++) begin
            e = (i < 8) ? 8'h80 >> i : 8'h00;
            @(posedge clk);
            cond <= PRE[i];
            repeat (6) @(posedge clk);
            host.wr(DEV_ADDR_DEF, OFF_EVENTS, EVT_CLEAR_CODE, r);
            check("ack", {7'h0, r}, 8'h00);
            @(posedge clk);
            cond <= POST[i];
            repeat (6) @(posedge clk);
            alert_is(e == 8'h00);
            host.rd(OFF_EVENTS, v);
            check("events", v, e);
            v = 8'($urandom);
            host.wr(DEV_ADDR_DEF, OFF_EVENTS, v == 8'hee ? 8'h00 : v, r);
            host.wr(DEV_ADDR_DEF, OFF_MASK, 8'h01 << gate_of(7 - i), r);
            alert_is(1'b1);
            host.rd(OFF_EVENTS, v);
            check("events kept", v, e);
            host.wr(DEV_ADDR_DEF, OFF_MASK, 8'h00, r);
            alert_is(e == 8'h00);
            host.wr(DEV_ADDR_DEF, OFF_EVENTS, EVT_CLEAR_CODE, r);
            alert_is(1'b1);
        end
        $display("test events done");
        host.wr(DEV_ADDR_DEF ^ 7'h01, OFF_MASK, 8'h1f, r);
        check("foreign nak", {7'h0, r}, 8'h01);
        host.wr(DEV_ADDR_DEF, OFF_MASK, 8'hff, r);
        host.rd(OFF_MASK, v);
        check("mask width", v, 8'h1f);
        // A master ACK continues the read with the next pointer's byte.
        host.rd2(OFF_EVENTS, v, e);
        check("burst events", v, 8'h00);
        check("burst mask", e, 8'h1f);
        $display("test mask done");
        conclude();
    end
endmodule
